// ### include/cp0_diag_pkg.sv
// constants, field positions and state encodings of the diagnostic registers
package cp0_diag_pkg;
   // register port widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 64;
   localparam int PA_W = 36;
   localparam int VA_W = 64;
   // register offsets on the plain register port
   localparam logic [ADDR_W-1:0] OFS_LL_ADDR = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_WIDE_CTX = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_DEBUG = 8'h10;
   // linked-load address field
   localparam int LL_PA_HI = 35;
   localparam int LL_PA_LO = 4;
   localparam int LL_W = LL_PA_HI - LL_PA_LO + 1;
   localparam logic [LL_W-1:0] LL_RESET = 32'h0;
   // wide translation context fields
   localparam int CTX_BASE_HI = 63;
   localparam int CTX_BASE_LO = 33;
   localparam int CTX_REGION_HI = 32;
   localparam int CTX_REGION_LO = 31;
   localparam int CTX_VPN_HI = 30;
   localparam int CTX_VPN_LO = 4;
   localparam int BASE_W = CTX_BASE_HI - CTX_BASE_LO + 1;
   localparam int REGION_W = CTX_REGION_HI - CTX_REGION_LO + 1;
   localparam int VPN_W = CTX_VPN_HI - CTX_VPN_LO + 1;
   localparam logic [CTX_VPN_LO-1:0] CTX_LOW_ZERO = 4'h0;
   // virtual address slices loaded on a miss
   localparam int VA_VPN_HI = 39;
   localparam int VA_VPN_LO = 13;
   localparam int VA_REGION_HI = 63;
   localparam int VA_REGION_LO = 62;
   // debug status bit positions
   localparam int DBG_DBD = 31;
   localparam int DBG_DM = 30;
   localparam int DBG_NIS = 14;
   localparam int DBG_TRS = 13;
   localparam int DBG_TLF = 11;
   localparam int DBG_BSF = 10;
   localparam int DBG_SST = 8;
   localparam int DBG_JRST = 7;
   localparam int DBG_W = 32;
   // debug handler state
   typedef enum logic [1:0] {
      DBG_IDLE = 2'b01,
      DBG_ACTIVE = 2'b10
   } debug_state_type;
endpackage

// ### hdl/cp0_diag_debug_regs.sv
// linked-load address, wide translation context and debug status registers
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ps

// hardware events arrive as one-cycle pulses from the pipeline; the three
// registers share one plain port with 64-bit data and one-cycle read latency
// limitation: the low debug status bits other than the four writable
// flags and bits 14 and 13 read as zero; the undefined context reset is
// chosen as zero so that reads straight after reset are repeatable
// a miss or debug exception seen while the handler runs is dropped here,
// so the pipeline need not hold it off itself
// fault flags give priority to hardware: a clear never hides a new fault

// Function
// R1: each linked load or linked load double overwrites the stored physical address
// R2: linked-load register holds address bits 35..4, resets to zero, read/write
// R3: on a miss, context bits 30:4 take virtual address bits 39..13
// R4: virtual address bit 12 never enters the page-pair field
// R5: page-pair field changes only on a miss, software writes ignore it
// R6: context bits 63:33 hold a software written page table base
// R7: context bits 32:31 hold the region code, read/write
// R8: debug status is read-only except the fault, bus, step and reset fields
// R9: delay-slot flag at bit 31 records a debug entry from a delay slot
// R10: debug-active flag sets on debug entry, clears on debug return
// R11: while debug-active, all interrupts and exceptions are masked
// R12: cache line locking is disabled while debug-active
// R13: coincident NMI sets bit 14 and still updates exception state
// R14: coincident NMI keeps the NMI vector out of the debug return pc
// R15: coincident refill sets bit 13
// R16: coincident refill updates exception state as a plain refill would
// R17: coincident refill keeps the refill vector out of the debug return pc
// R18: a miss also loads the region field, leaving the table base alone
// R19: load/store TLB fault in debug sets bit 11, write 0 clears, set wins
module cp0_diag_debug_regs (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [cp0_diag_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [cp0_diag_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [cp0_diag_pkg::DATA_W-1:0] reg_rdata,
   input wire logic ll_exec,
   input wire logic [cp0_diag_pkg::PA_W-1:0] ll_paddr,
   input wire logic tlb_miss,
   input wire logic [cp0_diag_pkg::VA_W-1:0] miss_vaddr,
   input wire logic debug_exc,
   input wire logic in_delay_slot,
   input wire logic nmi_req,
   input wire logic refill_req,
   input wire logic debug_return_instr,
   input wire logic ls_tlb_exc,
   input wire logic ls_buserr,
   output logic exc_mask,
   output logic cache_lock_en,
   output logic single_step_enable,
   output logic test_port_reset_ctl,
   output logic debug_entry,
   output logic nmi_state_update,
   output logic refill_state_update,
   output logic debug_return_pc_vector_inhibit
);
   import cp0_diag_pkg::*;

   // one register per field so that read-only parts cannot take a write
   logic [LL_W-1:0] ll_reg, ll_next;
   logic [BASE_W-1:0] base_reg, base_next;
   logic [REGION_W-1:0] region_reg, region_next;
   logic [VPN_W-1:0] vpn_reg, vpn_next;
   debug_state_type state_reg, state_next;
   logic dbd_reg, dbd_next;
   logic nis_reg, nis_next;
   logic trs_reg, trs_next;
   logic tlf_reg, tlf_next;
   logic bsf_reg, bsf_next;
   logic sst_reg, sst_next;
   logic jrst_reg, jrst_next;
   logic mask_reg, mask_next;
   logic lock_reg, lock_next;
   logic entry_reg, nmi_upd_reg, refill_upd_reg, inhibit_reg;
   logic entry_next, nmi_upd_next, refill_upd_next, inhibit_next;
   logic [DATA_W-1:0] rdata_reg, rdata_next;

   // decoded events and field slices
   logic dm;
   logic take_debug;
   logic take_return;
   logic wr_ll, wr_ctx, wr_dbg;
   logic take_miss;
   logic [LL_W-1:0] ll_slice;
   logic [VPN_W-1:0] miss_vpn;
   logic [REGION_W-1:0] miss_region;
   logic [DBG_W-1:0] dbg_word;

   // decode and event qualification
   assign dm = (state_reg == DBG_ACTIVE);
   // a second debug exception is masked while the handler runs
   assign take_debug = debug_exc && !dm; // R11
   assign take_return = debug_return_instr && dm; // R10
   // a miss seen in debug mode is masked and leaves the context alone
   assign take_miss = tlb_miss && !dm; // R11
   assign wr_ll = reg_wr && (reg_addr == OFS_LL_ADDR);
   assign wr_ctx = reg_wr && (reg_addr == OFS_WIDE_CTX);
   assign wr_dbg = reg_wr && (reg_addr == OFS_DEBUG);
   assign ll_slice = ll_paddr[LL_PA_HI:LL_PA_LO]; // R2
   // bit 12 is dropped: one entry maps an even/odd page pair
   assign miss_vpn = miss_vaddr[VA_VPN_HI:VA_VPN_LO]; // R3 R4
   assign miss_region = miss_vaddr[VA_REGION_HI:VA_REGION_LO]; // R18

   // next state of all software visible fields
   always_comb begin
      ll_next = ll_reg;
      base_next = base_reg;
      region_next = region_reg;
      vpn_next = vpn_reg;
      state_next = state_reg;
      dbd_next = dbd_reg;
      nis_next = nis_reg;
      trs_next = trs_reg;
      tlf_next = tlf_reg;
      bsf_next = bsf_reg;
      sst_next = sst_reg;
      jrst_next = jrst_reg;
      // hardware capture wins over a software write in the same cycle
      if (wr_ll) begin
         ll_next = reg_wdata[LL_W-1:0]; // R2
      end
      if (ll_exec) begin
         ll_next = ll_slice; // R1
      end
      // the page-pair field takes no software write
      if (wr_ctx) begin
         base_next = reg_wdata[CTX_BASE_HI:CTX_BASE_LO]; // R6
         region_next = reg_wdata[CTX_REGION_HI:CTX_REGION_LO]; // R7
      end
      if (take_miss) begin
         vpn_next = miss_vpn; // R3 R5
         region_next = miss_region; // R18
      end
      // only four debug fields accept writes, flags clear on zero
      if (wr_dbg) begin
         if (!reg_wdata[DBG_TLF]) begin
            tlf_next = 1'b0; // R19
         end
         if (!reg_wdata[DBG_BSF]) begin
            bsf_next = 1'b0; // R8
         end
         sst_next = reg_wdata[DBG_SST]; // R8
         jrst_next = reg_wdata[DBG_JRST]; // R8
      end
      // faults in the handler set the flags, beating a clear
      if (dm && ls_tlb_exc) begin
         tlf_next = 1'b1; // R19
      end
      if (dm && ls_buserr) begin
         bsf_next = 1'b1;
      end
      case (state_reg)
         DBG_IDLE: begin
            if (take_debug) begin
               state_next = DBG_ACTIVE; // R10
               dbd_next = in_delay_slot; // R9
               nis_next = nmi_req; // R13
               trs_next = refill_req; // R15
            end
         end
         DBG_ACTIVE: begin
            if (take_return) begin
               state_next = DBG_IDLE; // R10
            end
         end
         default: begin
            state_next = DBG_IDLE;
         end
      endcase
      // mask and lock follow the debug state from the same edge
      mask_next = (state_next == DBG_ACTIVE); // R11 R12
      // lock kept as its own flop so the output has no gate behind it
      lock_next = !(state_next == DBG_ACTIVE); // R12
   end

   // field registers; context fields get a defined zero at reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ll_reg <= LL_RESET;
         base_reg <= '0;
         region_reg <= '0;
         vpn_reg <= '0;
         state_reg <= DBG_IDLE;
         dbd_reg <= 1'b0;
         nis_reg <= 1'b0;
         trs_reg <= 1'b0;
         tlf_reg <= 1'b0;
         bsf_reg <= 1'b0;
         sst_reg <= 1'b0;
         jrst_reg <= 1'b0;
         mask_reg <= 1'b0;
         lock_reg <= 1'b1;
      end else begin
         ll_reg <= ll_next;
         base_reg <= base_next;
         region_reg <= region_next;
         vpn_reg <= vpn_next;
         state_reg <= state_next;
         dbd_reg <= dbd_next;
         nis_reg <= nis_next;
         trs_reg <= trs_next;
         tlf_reg <= tlf_next;
         bsf_reg <= bsf_next;
         sst_reg <= sst_next;
         jrst_reg <= jrst_next;
         mask_reg <= mask_next;
         lock_reg <= lock_next;
      end
   end

   // strobe next values, all qualified by an accepted debug entry
   always_comb begin
      entry_next = take_debug;
      nmi_upd_next = take_debug && nmi_req; // R13
      refill_upd_next = take_debug && refill_req; // R16
      // handler software fills the return pc instead of the vector
      inhibit_next = take_debug && (nmi_req || refill_req); // R14 R17
   end

   // one-cycle strobes to the exception unit on a debug entry
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         entry_reg <= 1'b0;
         nmi_upd_reg <= 1'b0;
         refill_upd_reg <= 1'b0;
         inhibit_reg <= 1'b0;
      end else begin
         entry_reg <= entry_next;
         nmi_upd_reg <= nmi_upd_next;
         refill_upd_reg <= refill_upd_next;
         inhibit_reg <= inhibit_next;
      end
   end

   // debug status word; unlisted bits read as zero
   always_comb begin
      dbg_word = '0;
      dbg_word[DBG_DBD] = dbd_reg; // R9
      dbg_word[DBG_DM] = dm; // R10
      dbg_word[DBG_NIS] = nis_reg; // R13
      dbg_word[DBG_TRS] = trs_reg; // R15
      dbg_word[DBG_TLF] = tlf_reg;
      dbg_word[DBG_BSF] = bsf_reg;
      dbg_word[DBG_SST] = sst_reg;
      dbg_word[DBG_JRST] = jrst_reg;
   end

   // read mux, unmapped offsets read zero
   // the read strobe gates the mux so idle cycles return zero
   always_comb begin
      rdata_next = '0;
      if (reg_rd) begin
         case (reg_addr)
            OFS_LL_ADDR: rdata_next = {{(DATA_W-LL_W){1'b0}}, ll_reg};
            OFS_WIDE_CTX: begin
               rdata_next = {base_reg, region_reg, vpn_reg, CTX_LOW_ZERO};
            end
            OFS_DEBUG: rdata_next = {{(DATA_W-DBG_W){1'b0}}, dbg_word};
            default: rdata_next = '0;
         endcase
      end
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_reg <= '0;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // outputs straight from flops
   assign reg_rdata = rdata_reg;
   assign exc_mask = mask_reg; // R11
   assign cache_lock_en = lock_reg; // R12
   assign single_step_enable = sst_reg;
   assign test_port_reset_ctl = jrst_reg;
   assign debug_entry = entry_reg;
   assign nmi_state_update = nmi_upd_reg;
   assign refill_state_update = refill_upd_reg;
   assign debug_return_pc_vector_inhibit = inhibit_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // linked-load capture and software access
   a_ll_capture: assert property (ll_exec |=> ll_reg == $past(ll_slice)) // R1
      else $error("linked-load address not captured");
   a_ll_sw_write: assert property (wr_ll && !ll_exec |=>
      ll_reg == $past(reg_wdata[LL_W-1:0])) // R2
      else $error("linked-load address write lost");

   // context fields on a miss and on a write
   a_vpn_on_miss: assert property (take_miss |=>
      vpn_reg == $past(miss_vpn)) // R3
      else $error("page-pair field not loaded on miss");
   a_vpn_read_only: assert property (!take_miss |=> $stable(vpn_reg)) // R5
      else $error("page-pair field changed without miss");
   a_base_on_miss: assert property (take_miss && !wr_ctx |=>
      $stable(base_reg) && region_reg == $past(miss_region)) // R18
      else $error("miss disturbed table base or region");
   a_ctx_write: assert property (wr_ctx && !take_miss |=>
      base_reg == $past(reg_wdata[CTX_BASE_HI:CTX_BASE_LO])) // R6
      else $error("table base write lost");

   // debug entry and return
   a_debug_entry: assert property (take_debug |=>
      dm && dbd_reg == $past(in_delay_slot) && debug_entry) // R9
      else $error("debug entry not recorded");
   a_debug_exit: assert property (take_return |=> !dm && !exc_mask) // R10
      else $error("debug-active not cleared on return");
   a_mask_lock: assert property (exc_mask == dm && cache_lock_en == !dm) // R12
      else $error("mask or lock disagrees with debug state");
   a_nested_masked: assert property (dm && debug_exc |=>
      $stable(dbd_reg) && !debug_entry) // R11
      else $error("debug exception taken while active");
   a_nmi_coincide: assert property (take_debug && nmi_req |=>
      nis_reg && nmi_state_update && debug_return_pc_vector_inhibit) // R13
      else $error("coincident nmi not flagged");
   a_refill_coincide: assert property (take_debug && refill_req |=>
      trs_reg && refill_state_update && debug_return_pc_vector_inhibit) // R15
      else $error("coincident refill not flagged");

   // fault flags: hardware set beats a software clear
   a_tlf_set_wins: assert property (dm && ls_tlb_exc |=> tlf_reg) // R19
      else $error("tlb fault flag not set");
   a_tlf_one_ignored: assert property (!tlf_reg && wr_dbg &&
      !(dm && ls_tlb_exc) |=> !tlf_reg) // R19
      else $error("tlb fault flag set by software");
   a_bsf_set_wins: assert property (dm && ls_buserr |=> bsf_reg) // R8
      else $error("bus error flag not set");

   // register bus: read data last one cycle, writes land where decoded
   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == '0) // R2
      else $error("read data present without a read strobe");
   a_ll_hold: assert property (!ll_exec && !wr_ll |=> $stable(ll_reg)) // R1
      else $error("linked-load address changed without cause");
   a_region_write: assert property (wr_ctx && !take_miss |=>
      region_reg == $past(reg_wdata[CTX_REGION_HI:CTX_REGION_LO])) // R7
      else $error("region write lost");
   a_dbg_writable: assert property (wr_dbg |=>
      single_step_enable == $past(reg_wdata[DBG_SST]) &&
      test_port_reset_ctl == $past(reg_wdata[DBG_JRST])) // R8
      else $error("step or test reset write lost");

   // entry flags, strobes and masking of events while the handler runs
   a_entry_flags_hold: assert property (!take_debug |=>
      $stable(dbd_reg) && $stable(nis_reg) && $stable(trs_reg)) // R9
      else $error("entry flags changed without debug entry");
   a_return_idle: assert property (!dm && debug_return_instr && !debug_exc
      |=> !dm) // R10
      else $error("return while idle changed debug state");
   a_inhibit_plain: assert property (take_debug && !nmi_req && !refill_req
      |=> !debug_return_pc_vector_inhibit && !nmi_state_update) // R14
      else $error("return pc inhibited without coincident event");
   a_entry_single: assert property (debug_entry |=> !debug_entry) // R10
      else $error("debug entry strobe longer than one cycle");
   a_miss_masked: assert property (dm && tlb_miss && !wr_ctx |=>
      $stable(region_reg) && $stable(vpn_reg)) // R11
      else $error("miss in debug mode changed the context");

   // main scenarios to reach in simulation
   c_entry_exit: cover property (take_debug ##[1:20] take_return);
   c_miss_masked: cover property (dm && tlb_miss);
   c_nmi_coincide: cover property (take_debug && nmi_req);
   c_refill_coincide: cover property (take_debug && refill_req);
   c_tlf_clear: cover property (tlf_reg && wr_dbg ##1 !tlf_reg);
endmodule

// ### test/testbench.sv
// register-level bench for the linked-load, context and debug registers
`timescale 1ns/1ps

module testbench;
   import cp0_diag_pkg::*;
   logic core_clk, sys_rst, reg_wr, reg_rd;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata, rd_val, ctx_exp;
   logic ll_exec, tlb_miss, debug_exc, in_delay_slot, nmi_req, refill_req;
   logic debug_return_instr, ls_tlb_exc, ls_buserr;
   logic exc_mask, cache_lock_en, single_step_enable, test_port_reset_ctl;
   logic debug_entry, nmi_state_update, refill_state_update;
   logic debug_return_pc_vector_inhibit;
   logic [VA_W-1:0] va;
   int mismatches = 0;
   int check_count = 0;

   cp0_diag_debug_regs cp0_diag_debug_regs_inst (.core_clk(core_clk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ll_exec(ll_exec), .ll_paddr(va[PA_W-1:0]), .tlb_miss(tlb_miss),
      .miss_vaddr(va), .debug_exc(debug_exc), .in_delay_slot(in_delay_slot),
      .nmi_req(nmi_req), .refill_req(refill_req),
      .debug_return_instr(debug_return_instr), .ls_tlb_exc(ls_tlb_exc),
      .ls_buserr(ls_buserr), .exc_mask(exc_mask),
      .cache_lock_en(cache_lock_en), .single_step_enable(single_step_enable),
      .test_port_reset_ctl(test_port_reset_ctl), .debug_entry(debug_entry),
      .nmi_state_update(nmi_state_update),
      .refill_state_update(refill_state_update),
      .debug_return_pc_vector_inhibit(debug_return_pc_vector_inhibit));

   // free-running core clock, 4 ns period
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one-cycle write; fault pulses alongside to test set-beats-clear
   task automatic wr(input logic [7:0] a, input logic [63:0] d,
                     input logic flt);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      ls_tlb_exc <= flt;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      ls_tlb_exc <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [63:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rd_val = reg_rdata;
      check(rd_val, exp);
   endtask

   // ev = {ll_exec, tlb_miss, debug_exc, return, tlb fault, bus error}
   task automatic fire(input logic [5:0] ev);
      @(posedge core_clk);
      {ll_exec, tlb_miss, debug_exc, debug_return_instr, ls_tlb_exc,
       ls_buserr} <= ev;
      @(posedge core_clk);
      {ll_exec, tlb_miss, debug_exc, debug_return_instr, ls_tlb_exc,
       ls_buserr} <= 6'h0;
      #1;
   endtask

   // pack the status outputs except single_step_enable and test_port_reset_ctl so one compare covers them
   function automatic logic [63:0] outs();
      return {58'h0, exc_mask, cache_lock_en, debug_entry, nmi_state_update,
              refill_state_update, debug_return_pc_vector_inhibit};
   endfunction

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // a hang cannot outlast a few thousand cycles of these short tests
   initial begin
      #20000;
      mismatches++;
      final_report();
   end

   initial begin
      {reg_wr, reg_rd, ll_exec, tlb_miss, debug_exc, in_delay_slot} = 6'h0;
      {nmi_req, refill_req, debug_return_instr, ls_tlb_exc, ls_buserr} = 5'h0;
      reg_addr = 8'h00;
      reg_wdata = 64'h0;
      va = 64'h0;
      sys_rst = 1'b1;
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      #1 check(outs(), 64'h10);
      rd(OFS_LL_ADDR, 64'h0);
      rd(OFS_DEBUG, 64'h0);
      rd(8'h18, 64'h0);
      $display("test reset done");

      wr(OFS_LL_ADDR, 64'hdead_beef_1234_5678, 1'b0);
      wr(8'h18, 64'hffff_ffff_ffff_ffff, 1'b0);
      rd(OFS_LL_ADDR, 64'h0000_0000_1234_5678);
      @(posedge core_clk);
      #1 check(reg_rdata, 64'h0);
      va = 64'h0000_0009_8765_4321;
      fire(6'h20);
      rd(OFS_LL_ADDR, 64'h0000_0000_9876_5432);
      $display("test linked load done");

      wr(OFS_WIDE_CTX, 64'hffff_ffff_ffff_ffff, 1'b0);
      rd(OFS_WIDE_CTX, 64'hffff_ffff_8000_0000);
      va = 64'h4000_00ab_cdef_f000; // bit 12 set on purpose
      fire(6'h10);
      ctx_exp = {31'h7fff_ffff, va[63:62], va[39:13], 4'h0};
      rd(OFS_WIDE_CTX, ctx_exp);
      wr(OFS_WIDE_CTX, 64'h0000_0001_0000_0000, 1'b0);
      ctx_exp = {31'h0, 2'b10, va[39:13], 4'h0};
      rd(OFS_WIDE_CTX, ctx_exp);
      $display("test context done");

      // debug entry from a delay slot with a coincident nmi
      in_delay_slot <= 1'b1;
      nmi_req <= 1'b1;
      fire(6'h08);
      check(outs(), 64'h2d);
      @(posedge core_clk);
      #1 check(outs(), 64'h20);
      in_delay_slot <= 1'b0;
      nmi_req <= 1'b0;
      rd(OFS_DEBUG, 64'hc000_4000);
      va = 64'hc000_0055_5555_5000;
      fire(6'h10);
      rd(OFS_WIDE_CTX, ctx_exp);
      refill_req <= 1'b1;
      fire(6'h08);
      check(outs(), 64'h20);
      refill_req <= 1'b0;
      fire(6'h03);
      rd(OFS_DEBUG, 64'hc000_4c00);
      wr(OFS_DEBUG, 64'h0000_0000_0000_0180, 1'b1);
      rd(OFS_DEBUG, 64'hc000_4980);
      check({62'h0, single_step_enable, test_port_reset_ctl}, 64'h3);
      wr(OFS_DEBUG, 64'h0000_0000_ffff_ffff, 1'b0);
      rd(OFS_DEBUG, 64'hc000_4980);
      $display("test debug entry done");

      fire(6'h04);
      check(outs(), 64'h10);
      rd(OFS_DEBUG, 64'h8000_4980);
      refill_req <= 1'b1;
      fire(6'h08);
      check(outs(), 64'h2b);
      @(posedge core_clk);
      #1 check(outs(), 64'h20);
      refill_req <= 1'b0;
      rd(OFS_DEBUG, 64'h4000_2980);
      fire(6'h04);
      $display("test refill coincide done");
      final_report();
   end
endmodule
